// *** hdl/nv_shadow_host.sv ***
// host controller driving the nonvolatile shadow sram pins
// assumes the memory sits on the pins below and has no clock of its own
`timescale 1ns/100ps
`include "nv_shadow_cfg.svh"
module nv_shadow_host
  import nv_shadow_pkg::*;
#(
  parameter int unsigned STORE_CYC = `US_TO_CYC(`STORE_DURATION_US),
  parameter int unsigned POWERUP_CYC = `US_TO_CYC(`POWERUP_RECALL_DURATION_US)
) (
  input wire logic mclk,
  input wire logic rst_b,
  // user command port
  input wire logic req_valid,
  input wire nv_shadow_pkg::op_t req_op,
  input wire logic [10:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  // supply monitor: high while supply above trigger level
  input wire logic supply_ok,
  // memory pins
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_drive_n,
  output logic [10:0] address_lines,
  input wire logic [7:0] data_lines_i,
  output logic [7:0] data_lines_o,
  output logic data_lines_oe
);
  import nv_shadow_pkg::*;

  localparam int unsigned SETUP_CYC = `NS_TO_CYC(`T_SETUP_NS);
  localparam int unsigned PULSE_CYC = `NS_TO_CYC(`T_PULSE_NS);
  localparam int unsigned GAP_CYC = `NS_TO_CYC(`T_CYCLE_NS - `T_PULSE_NS);
  localparam int unsigned RECALL_CYC = `US_TO_CYC(`RECALL_DURATION_US);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] din_s1_q, din_s2_q;
  logic sup_s1_q, sup_s2_q, sup_prev_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= data_lines_i;
      din_s2_q <= din_s1_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sup_s1_q <= 1'b0;
      sup_s2_q <= 1'b0;
      sup_prev_q <= 1'b0;
    end else begin
      sup_s1_q <= supply_ok;
      sup_s2_q <= sup_s1_q;
      sup_prev_q <= sup_s2_q;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  state_t state_q;
  op_t op_q;
  logic [2:0] step_q;
  logic [10:0] addr_q;
  logic [7:0] wdata_q;
  logic pwr_busy_q;
  logic tmr_load;
  logic [31:0] tmr_count;
  logic tmr_done;
  logic seq_op;
  logic last_step;
  logic [10:0] step_addr;

  assign seq_op = (op_q == op_store) || (op_q == op_recall);
  assign last_step = !seq_op || (step_q == 3'h5);

  // sequence addresses; sixth picks store or recall
  always_comb begin
    unique case (step_q)
      3'h0: step_addr = `SEQ_ADDR_0;
      3'h1: step_addr = `SEQ_ADDR_1;
      3'h2: step_addr = `SEQ_ADDR_2;
      3'h3: step_addr = `SEQ_ADDR_3;
      3'h4: step_addr = `SEQ_ADDR_4;
      default: step_addr = (op_q == op_store) ? `SEQ_STORE : `SEQ_RECALL;
    endcase
  end

  // power-up or low supply: device runs its own recall once supply is back
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_busy_q <= 1'b1;
    end else if (!sup_s2_q) begin
      pwr_busy_q <= 1'b1;
    end else if (!sup_prev_q) begin
      pwr_busy_q <= 1'b1;
    end else if (pwr_busy_q && tmr_done && state_q == st_wait) begin
      pwr_busy_q <= 1'b0;
    end
  end

  always_comb begin
    tmr_load = 1'b0;
    tmr_count = 32'h0000_0000;
    if (sup_s2_q && !sup_prev_q) begin
      tmr_load = 1'b1;
      tmr_count = POWERUP_CYC;
    end else begin
      unique case (state_q)
        st_idle: begin
          if (req_valid && !pwr_busy_q) begin
            tmr_load = 1'b1;
            tmr_count = SETUP_CYC;
          end
        end
        st_setup: begin
          if (tmr_done) begin
            tmr_load = 1'b1;
            tmr_count = PULSE_CYC;
          end
        end
        st_pulse: begin
          if (tmr_done) begin
            tmr_load = 1'b1;
            tmr_count = GAP_CYC;
          end
        end
        st_hold: begin
          if (tmr_done) begin
            tmr_load = 1'b1;
            if (!last_step) begin
              tmr_count = SETUP_CYC;
            end else if (op_q == op_store) begin
              tmr_count = STORE_CYC;
            end else if (op_q == op_recall) begin
              tmr_count = RECALL_CYC;
            end else begin
              tmr_count = 32'h0000_0001;
            end
          end
        end
        st_wait: ;
      endcase
    end
  end

  nv_wait_timer u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // state and request capture
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= st_wait;
      op_q <= op_read;
      step_q <= 3'h0;
      addr_q <= 11'h000;
      wdata_q <= 8'h00;
    end else if (!sup_s2_q || (sup_s2_q && !sup_prev_q)) begin
      state_q <= st_wait; // no accesses while the device restores
    end else begin
      unique case (state_q)
        st_idle: begin
          // store is pointless below trigger level; the device blocks it
          if (req_valid && !pwr_busy_q) begin
            state_q <= st_setup;
            op_q <= req_op;
            step_q <= 3'h0;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
          end
        end
        st_setup: if (tmr_done) state_q <= st_pulse;
        st_pulse: if (tmr_done) state_q <= st_hold;
        st_hold: begin
          if (tmr_done) begin
            if (!last_step) begin
              step_q <= step_q + 3'h1; // nothing else interleaves
              state_q <= st_setup;
            end else begin
              state_q <= st_wait;
            end
          end
        end
        st_wait: if (tmr_done && !tmr_load) state_q <= st_idle;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      chip_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_drive_n <= 1'b1;
      address_lines <= 11'h000;
      data_lines_o <= 8'h00;
      data_lines_oe <= 1'b0;
    end else begin
      // select pulses only in the pulse phase; address steady around it
      chip_select_n <= !(state_q == st_pulse && sup_s2_q);
      // strobe only in a write pulse, never in a wait
      write_strobe_n <= !(state_q == st_pulse && op_q == op_write);
      output_drive_n <= !((state_q == st_setup || state_q == st_pulse) && op_q == op_read);
      if (state_q == st_setup || state_q == st_pulse || state_q == st_hold) begin
        address_lines <= seq_op ? step_addr : addr_q;
      end
      data_lines_o <= wdata_q;
      // data held through the hold phase past the rising select
      data_lines_oe <= (state_q == st_setup || state_q == st_pulse || state_q == st_hold)
                       && op_q == op_write;
    end
  end

  // ------------------------------------------------------------
  // user answer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      req_ready <= (state_q == st_idle) && !pwr_busy_q && !req_valid && sup_s2_q;
      // sample late in the pulse; sync delay is covered by the pulse width
      rsp_valid <= (state_q == st_pulse) && tmr_done && op_q == op_read;
      if (state_q == st_pulse && tmr_done && op_q == op_read) begin
        rsp_rdata <= din_s2_q;
      end
    end
  end
endmodule : nv_shadow_host

// *** hdl/nv_shadow_cfg.svh ***
// constants for the host-side controller of the nonvolatile shadow sram
// assumes a 200 MHz mclk; all pin timing rounded to whole cycles
`ifndef NV_SHADOW_CFG_SVH
`define NV_SHADOW_CFG_SVH

`define CLK_PERIOD_PS 5000
// pin timing in ns for the slowest speed grade
`define T_CYCLE_NS 45
`define T_PULSE_NS 30
`define T_SETUP_NS 15
// long waits
`define STORE_DURATION_US 10000
`define RECALL_DURATION_US 20
`define POWERUP_RECALL_DURATION_US 550
`define NS_TO_CYC(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// works in ns so a 10 ms store count stays inside 32-bit integer math
`define US_TO_CYC(us) (((us) * 1000 + (`CLK_PERIOD_PS / 1000) - 1) / (`CLK_PERIOD_PS / 1000))

`define SEQ_ADDR_0 11'h000
`define SEQ_ADDR_1 11'h555
`define SEQ_ADDR_2 11'h2AA
`define SEQ_ADDR_3 11'h7FF
`define SEQ_ADDR_4 11'h0F0
`define SEQ_STORE 11'h70F
`define SEQ_RECALL 11'h70E

`endif

// *** hdl/nv_shadow_pkg.sv ***
// types shared by the host-side controller files
// assumes the cfg header for all numeric constants
package nv_shadow_pkg;
  typedef enum logic [1:0] {
    op_read = 2'h0,
    op_write = 2'h1,
    op_store = 2'h2,
    op_recall = 2'h3
  } op_t;

  typedef enum logic [4:0] {
    st_idle = 5'b0_0001,
    st_setup = 5'b0_0010,
    st_pulse = 5'b0_0100,
    st_hold = 5'b0_1000,
    st_wait = 5'b1_0000
  } state_t;
endpackage : nv_shadow_pkg

// *** hdl/nv_wait_timer.sv ***
// loadable down-counter used for pin phases and long device busy waits
// assumes a single mclk domain
`timescale 1ns/100ps
module nv_wait_timer (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [31:0] count,
  output logic done
);
  logic [31:0] cnt_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0000_0000;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != 32'h0000_0000) begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

  // no load term: callers derive load from done, which would close a loop
  assign done = (cnt_q == 32'h0000_0000);
endmodule : nv_wait_timer

// *** sim/nv_shadow_host_monitor.sv ***
// pin and user-port checks for the shadow memory host controller
// assumes binding onto nv_shadow_host, single mclk domain
`timescale 1ns/100ps
module nv_host_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic supply_ok,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic [10:0] address_lines,
  input wire logic [7:0] data_lines_o,
  input wire logic data_lines_oe
);
  logic wr;
  assign wr = !chip_select_n && !write_strobe_n;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_ADDR_HOLD: assert property (wr && $past(wr) |-> $stable(address_lines))
    else $error("address moved in write");
  AST_DATA_HOLD: assert property (wr && $past(wr) |-> $stable(data_lines_o))
    else $error("data moved in write");
  AST_DRV_OFF_WR: assert property (!write_strobe_n |-> output_drive_n)
    else $error("drive low in write");
  AST_WR_OE: assert property (wr |-> data_lines_oe)
    else $error("write without bus drive");
  AST_NO_FIGHT: assert property (!output_drive_n |-> !data_lines_oe)
    else $error("bus contention");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("response too long");
  AST_SEL_WIDTH: assert property ($fell(chip_select_n) |-> !chip_select_n [*6])
    else $error("select pulse short");
  AST_SEQ_READ: assert property (!chip_select_n && !data_lines_oe |-> write_strobe_n)
    else $error("strobe low in read");
  AST_LOW_SUPPLY: assert property (!supply_ok [*5] |-> !req_ready)
    else $error("ready at low supply");
  C_WR: cover property (wr);
  C_RSP: cover property (rsp_valid);
  C_STORE: cover property ($fell(chip_select_n) && address_lines == 11'h70F);
endmodule : nv_host_chk

bind nv_shadow_host nv_host_chk i_chk (.mclk(mclk), .rst_b(rst_b), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .supply_ok(supply_ok), .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
  .address_lines(address_lines), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));

// *** sim/nv_sram_model.sv ***
// behavioural shadow memory seen at its pins, times in ns
// assumes the host holds pins steady across each access
`timescale 1ns/100ps
module nv_sram_model #(
  parameter int STORE_NS = 200,
  parameter int RECALL_NS = 1000,
  parameter int PWR_NS = 200
) (
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic [10:0] address_lines,
  input wire logic [7:0] data_lines_o,
  input wire logic supply_ok,
  output logic [7:0] data_lines_i,
  output logic fault
);
  logic [7:0] sram [2048];
  logic [7:0] nv [2048];
  logic [7:0] last = 8'h00;
  logic [10:0] seq [5] = '{11'h000, 11'h555, 11'h2AA, 11'h7FF, 11'h0F0};
  int step = 0;
  logic busy = 1'b1;
  logic wr;
  logic drv;
  logic wr_seen = 1'b0;
  assign wr = !chip_select_n && !write_strobe_n && !busy;
  assign drv = !chip_select_n && !output_drive_n && write_strobe_n && !busy;
  initial fault = 1'b0;
  // released bus shows the inverse, never a stale byte
  always @* begin
    if (drv) last = sram[address_lines];
    data_lines_i = drv ? sram[address_lines] : ~last;
  end
  always @(negedge wr) begin
    sram[address_lines] = data_lines_o;
    step = 0;
  end
  always @(negedge write_strobe_n) if (!output_drive_n) fault = 1'b1;
  always @(address_lines) if (wr) fault = 1'b1;
  // flag set mid-access, so the select edge never races the strobe edge
  always @(posedge wr) wr_seen = 1'b1;
  always @(posedge chip_select_n) begin
    if (!busy && !wr_seen) begin
      if (step == 5 && address_lines == 11'h70F && supply_ok) begin
        busy = 1'b1;
        #(STORE_NS) nv = sram;
        busy = 1'b0;
      end else if (step == 5 && address_lines == 11'h70E) begin
        busy = 1'b1;
        foreach (sram[i]) sram[i] = 8'h00;
        #(RECALL_NS) sram = nv;
        busy = 1'b0;
      end
      step = (step < 5 && address_lines == seq[step]) ? step + 1 :
             (address_lines == 11'h000) ? 1 : 0;
    end
    wr_seen = 1'b0;
  end
  always @(posedge supply_ok) begin
    busy = 1'b1;
    #(PWR_NS) sram = nv;
    if (!chip_select_n && !write_strobe_n) fault = 1'b1;
    busy = 1'b0;
  end
endmodule : nv_sram_model

// *** sim/tb_top.sv ***
// self-checking bench: host controller against the memory model
// assumes short store and power-up counts for simulation
`timescale 1ns/100ps
module tb_top;
  import nv_shadow_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic supply_ok = 1'b0;
  op_t req_op = op_read;
  logic [10:0] req_addr = 11'h000;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] rsp_rdata, data_lines_i, data_lines_o, rd;
  logic req_ready, rsp_valid, chip_select_n, write_strobe_n, output_drive_n;
  logic data_lines_oe, fault;
  logic [10:0] address_lines;
  int err_total = 0;
  int n_tests = 0;
  always #2.5 mclk = ~mclk;
  nv_shadow_host #(.STORE_CYC(50), .POWERUP_CYC(50)) i_dut (.mclk(mclk), .rst_b(rst_b),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .supply_ok(supply_ok), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .output_drive_n(output_drive_n), .address_lines(address_lines),
    .data_lines_i(data_lines_i), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));
  nv_sram_model i_mem (.chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .output_drive_n(output_drive_n), .address_lines(address_lines),
    .data_lines_o(data_lines_o), .supply_ok(supply_ok), .data_lines_i(data_lines_i),
    .fault(fault));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic tick(inout int n, input int lim);
    @(negedge mclk);
    n++;
    if (n > lim) begin
      chk(8'h00, 8'h01);
      conclude();
    end
  endtask : tick
  // long bound covers a recall busy time of 4000 cycles
  task automatic req(input op_t op, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1) tick(n, 5000);
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    if (op == op_read) begin
      while (rsp_valid !== 1'b1) tick(n, 40);
      rd = rsp_rdata;
    end
  endtask : req
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rw;
    logic [10:0] a [3] = '{11'h000, 11'h7FF, 11'h555};
    foreach (a[i]) req(op_write, a[i], a[i][7:0] ^ 8'h5A);
    foreach (a[i]) begin
      req(op_read, a[i], 8'h00);
      chk(rd, a[i][7:0] ^ 8'h5A);
    end
  endtask : t_rw
  task automatic t_store_recall;
    req(op_write, 11'h123, 8'h3C);
    req(op_store, 11'h000, 8'h00);
    req(op_write, 11'h123, 8'hC3);
    req(op_read, 11'h123, 8'h00);
    chk(rd, 8'hC3);
    repeat (2) req(op_recall, 11'h000, 8'h00);
    req(op_read, 11'h123, 8'h00);
    chk(rd, 8'h3C);
    req(op_read, 11'h7FF, 8'h00);
    chk(rd, 8'hA5);
  endtask : t_store_recall
  task automatic t_power;
    req(op_write, 11'h123, 8'h77);
    supply_ok = 1'b0;
    repeat (8) @(negedge mclk);
    chk({7'h00, req_ready}, 8'h00);
    supply_ok = 1'b1;
    req(op_read, 11'h123, 8'h00);
    chk(rd, 8'h3C);
  endtask : t_power
  initial begin
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    supply_ok = 1'b1;
    t_rw();
    t_store_recall();
    t_power();
    chk({7'h00, fault}, 8'h00);
    conclude();
  end
endmodule : tb_top
